// File: core/dme_consts.svh
`ifndef DME_CONSTS_SVH
`define DME_CONSTS_SVH

// =====================================================================
// Array geometry
`define DME_MEM_DEPTH 128
`define DME_PAGE_BYTES 8
`define DME_CTRL_CODE 4'ha

// =====================================================================
// Serial framing
`define DME_INIT_LAST 4'h9
`define DME_LAST_BIT 4'h7
`define DME_NULL_SLOT 4'h8
`define DME_BITS_DONE 4'h8
`define DME_SYNC_W 6

// =====================================================================
// Reset values
`define DME_PTR_RESET 7'h00
`define DME_SYNC_RESET 1'b0

// =====================================================================
// Timing
`define DME_CLK_KHZ 125000
`define DME_TWR_MS 10
`define DME_TWR_CYCLES (`DME_TWR_MS * `DME_CLK_KHZ)
`define DME_TIMER_W 21

`endif

// File: core/dme_pkg.sv
package dme_pkg;

    typedef logic [7:0] dme_byte_t;
    typedef logic [6:0] dme_addr_t;

    // Gray along idle -> receive -> ack -> send -> master ack
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RX = 3'h1,
        ST_ACK = 3'h3,
        ST_TX = 3'h2,
        ST_MACK = 3'h6
    } dme_state_t;

    typedef enum logic [1:0] {
        KIND_CTRL = 2'h0,
        KIND_WORD = 2'h1,
        KIND_DATA = 2'h3
    } dme_kind_t;

endpackage

// File: core/dme_port.sv
`timescale 1ns/1ps
`include "dme_consts.svh"

// =====================================================================
// Contract
// - Array holds 128 bytes of eight bits
// - Own clock per mode, one shared data line
// - Power-up enters transmit-only mode
// - SCL falling edge switches to bidirectional mode
// - Bidirectional mode kept until power-up
// - New bit on transmit-only clock rising edge
// - Eight-bit bytes, each followed by null slot
// - Most significant bit sent first
// - Consecutive addresses, wrapping without end
// - Data line released during nine sync clocks
// - Tenth rising edge outputs first msb
// - Stream start address is undefined
// - Writes allowed only while transmit clock high
// - Self-timed write done within 10 ms
// - Page buffer holds up to eight bytes
// - Control byte 1010, three ignored, read bit
// - No acknowledge while write cycle runs
// - Page write bumps only low three bits
// - Write cycle starts on stop condition
module dme_port
    import dme_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = `DME_TWR_CYCLES
)
(
    // System clock and power-up reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Transmit-only clock, also write enable
    input wire logic transmit_only_clock_i,
    // Bidirectional clock
    input wire logic scl_i,
    // Shared data line
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Status
    output logic bidir_mode_o,
    output logic write_busy_o
);

    // =================================================================
    // Storage
    dme_byte_t mem [0:`DME_MEM_DEPTH-1];
    dme_byte_t pbuf [0:`DME_PAGE_BYTES-1];

    logic [`DME_SYNC_W-1:0] sync_in;
    logic [`DME_SYNC_W-1:0] sync_out;
    logic scl_s;
    logic sda_s;
    logic wp_s;
    logic txb_s;
    logic txoe_s;
    logic req_s;
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;

    logic tx_bit;
    logic tx_oe;
    logic req_tgl;
    dme_byte_t fetch_data;
    dme_addr_t tx_addr;
    logic req_seen;

    dme_state_t state;
    dme_state_t next_state;
    dme_kind_t kind;
    dme_kind_t next_kind;
    logic [3:0] bitcnt;
    logic [3:0] next_bitcnt;
    dme_byte_t shreg;
    dme_byte_t next_shreg;
    logic rw;
    logic next_rw;
    logic mack;
    logic next_mack;
    dme_addr_t ptr;
    dme_addr_t next_ptr;
    logic [`DME_PAGE_BYTES-1:0] pvalid;
    logic [`DME_PAGE_BYTES-1:0] next_pvalid;
    logic [`DME_TIMER_W-1:0] timer;
    logic [`DME_TIMER_W-1:0] next_timer;
    logic next_busy;
    logic next_mode;
    logic next_sda_o;
    logic next_sda_oe;
    logic pbuf_we;
    logic mem_we;
    dme_byte_t rd_byte;
    logic [2:0] cidx;

    function automatic logic ctrl_match(input dme_byte_t b);
        ctrl_match = (b[7:4] == `DME_CTRL_CODE);
    endfunction

    // =================================================================
    // Crossings into the system domain
    assign sync_in = {req_tgl, tx_oe, tx_bit, transmit_only_clock_i,
                      sda_i, scl_i};
    assign scl_s = sync_out[0];
    assign sda_s = sync_out[1];
    assign wp_s = sync_out[2];
    assign txb_s = sync_out[3];
    assign txoe_s = sync_out[4];
    assign req_s = sync_out[5];

    dme_sync #(.WIDTH(`DME_SYNC_W)) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i(sync_in),
        .sync_o(sync_out)
    );

    dme_txo u_txo (
        .transmit_only_clock_i(transmit_only_clock_i),
        .reset_i(reset_i),
        .bidir_mode_i(bidir_mode_o),
        .fetch_data_i(fetch_data),
        .tx_bit_o(tx_bit),
        .tx_oe_o(tx_oe),
        .req_tgl_o(req_tgl)
    );

    assign scl_rise = scl_s && !scl_q;
    assign scl_fall = !scl_s && scl_q;
    assign start_c = scl_s && scl_q && sda_q && !sda_s;
    assign stop_c = scl_s && scl_q && !sda_q && sda_s;
    assign rd_byte = mem[ptr];
    assign cidx = timer[2:0];
    assign mem_we = write_busy_o && (timer[`DME_TIMER_W-1:3] == 18'h0)
                    && pvalid[cidx];

    // =================================================================
    // Stream fetch: next byte after each consumed one, wrapping
    // Start address is whatever reset leaves; hosts must not rely on it
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            tx_addr <= `DME_PTR_RESET;
            req_seen <= 1'b0;
            fetch_data <= 8'h00;
            scl_q <= 1'b0;
            sda_q <= 1'b0;
        end
        else
        begin
            tx_addr <= tx_addr + {6'h00, req_s ^ req_seen};
            req_seen <= req_s;
            fetch_data <= mem[tx_addr];
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // =================================================================
    // Mode control and slave sequencer
    always_comb
    begin
        next_state = state;
        next_kind = kind;
        next_bitcnt = bitcnt;
        next_shreg = shreg;
        next_rw = rw;
        next_mack = mack;
        next_ptr = ptr;
        next_pvalid = pvalid;
        next_timer = timer;
        next_busy = write_busy_o;
        next_mode = bidir_mode_o;
        next_sda_o = 1'b0;
        next_sda_oe = sda_oe_o;
        pbuf_we = 1'b0;
        if (write_busy_o)
        begin
            if (timer == `DME_TIMER_W'(WRITE_CYCLES - 1))
            begin
                next_busy = 1'b0;
                next_pvalid = '0;
            end
            else
            begin
                next_timer = timer + `DME_TIMER_W'(1);
            end
        end
        if (!bidir_mode_o)
        begin
            // Stream owns the line until the first SCL fall
            next_sda_o = txb_s;
            next_sda_oe = txoe_s;
            if (scl_fall)
            begin
                next_mode = 1'b1;
                next_sda_oe = 1'b0;
            end
        end
        else if (start_c)
        begin
            next_state = ST_RX;
            next_kind = KIND_CTRL;
            next_bitcnt = 4'h0;
            next_sda_oe = 1'b0;
        end
        else if (stop_c)
        begin
            next_state = ST_IDLE;
            next_sda_oe = 1'b0;
            if (kind == KIND_DATA && pvalid != '0 && !write_busy_o)
            begin
                if (wp_s)
                begin
                    next_busy = 1'b1;
                    next_timer = '0;
                end
                else
                begin
                    next_pvalid = '0;
                end
            end
        end
        else
        begin
            case (state)
                ST_RX:
                begin
                    if (scl_rise && bitcnt != `DME_BITS_DONE)
                    begin
                        next_shreg = {shreg[6:0], sda_s};
                        next_bitcnt = bitcnt + 4'h1;
                    end
                    else if (scl_fall && bitcnt == `DME_BITS_DONE)
                    begin
                        next_state = ST_ACK;
                        next_sda_oe = 1'b1;
                        if (kind == KIND_CTRL)
                        begin
                            next_rw = shreg[0];
                            if (!ctrl_match(shreg) || write_busy_o)
                            begin
                                next_state = ST_IDLE;
                                next_sda_oe = 1'b0;
                            end
                        end
                        else if (kind == KIND_WORD)
                        begin
                            next_ptr = shreg[6:0];
                            next_pvalid = '0;
                        end
                        else
                        begin
                            pbuf_we = 1'b1;
                            next_pvalid[ptr[2:0]] = 1'b1;
                            next_ptr = {ptr[6:3], ptr[2:0] + 3'h1};
                        end
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        next_bitcnt = 4'h0;
                        next_sda_oe = 1'b0;
                        if (kind == KIND_CTRL && rw)
                        begin
                            next_state = ST_TX;
                            next_shreg = rd_byte;
                            next_sda_oe = !rd_byte[7];
                            next_bitcnt = 4'h1;
                        end
                        else
                        begin
                            next_state = ST_RX;
                            next_kind = (kind == KIND_CTRL) ? KIND_WORD
                                                            : KIND_DATA;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_fall && bitcnt == `DME_BITS_DONE)
                    begin
                        next_state = ST_MACK;
                        next_sda_oe = 1'b0;
                        next_ptr = ptr + 7'h01;
                    end
                    else if (scl_fall)
                    begin
                        next_sda_oe = !shreg[6];
                        next_shreg = {shreg[6:0], 1'b0};
                        next_bitcnt = bitcnt + 4'h1;
                    end
                end
                ST_MACK:
                begin
                    if (scl_rise)
                    begin
                        next_mack = !sda_s;
                    end
                    else if (scl_fall && mack)
                    begin
                        next_state = ST_TX;
                        next_shreg = rd_byte;
                        next_sda_oe = !rd_byte[7];
                        next_bitcnt = 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        next_state = ST_IDLE;
                    end
                end
                default:
                begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state <= ST_IDLE;
            kind <= KIND_CTRL;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            rw <= 1'b0;
            mack <= 1'b0;
            ptr <= `DME_PTR_RESET;
            pvalid <= '0;
            timer <= '0;
            write_busy_o <= 1'b0;
            bidir_mode_o <= 1'b0;
            sda_o <= 1'b1;
            sda_oe_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            kind <= next_kind;
            bitcnt <= next_bitcnt;
            shreg <= next_shreg;
            rw <= next_rw;
            mack <= next_mack;
            ptr <= next_ptr;
            pvalid <= next_pvalid;
            timer <= next_timer;
            write_busy_o <= next_busy;
            bidir_mode_o <= next_mode;
            sda_o <= next_sda_o;
            sda_oe_o <= next_sda_oe;
        end
    end

    // Nonvolatile, so no reset; plain always allows an outside preload
    always @(posedge clk_i)
    begin
        if (pbuf_we)
        begin
            pbuf[ptr[2:0]] <= shreg;
        end
        if (mem_we)
        begin
            mem[{ptr[6:3], cidx}] <= pbuf[cidx];
        end
    end

    // =================================================================
    // Checks
    sequence s_commit;
        write_busy_o [*8];
    endsequence

    chk_mode_sticky: assert property (
        @(posedge clk_i) disable iff (reset_i)
        bidir_mode_o |=> bidir_mode_o)
        else $error("mode fell back to transmit-only");

    chk_mode_switch: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (!bidir_mode_o && scl_fall) |=> bidir_mode_o)
        else $error("scl fall did not switch mode");

    chk_switch_cause: assert property (
        @(posedge clk_i) disable iff (reset_i)
        $rose(bidir_mode_o) |-> $past(scl_fall))
        else $error("mode set without scl fall");

    chk_stream_line: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !bidir_mode_o ##1 !bidir_mode_o |-> sda_oe_o == $past(txoe_s))
        else $error("stream not on data line");

    chk_busy_noack: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (bidir_mode_o && write_busy_o) |-> !sda_oe_o)
        else $error("acknowledge during write cycle");

    chk_write_start: assert property (
        @(posedge clk_i) disable iff (reset_i)
        $rose(write_busy_o) |-> $past(stop_c) && $past(wp_s) ##0 s_commit)
        else $error("write cycle start wrong");

    chk_write_time: assert property (
        @(posedge clk_i) disable iff (reset_i)
        write_busy_o |-> timer < WRITE_CYCLES)
        else $error("write cycle overran");

    chk_page_wrap: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (pbuf_we && !start_c && !stop_c) |=>
            ptr[6:3] == $past(ptr[6:3])
            && ptr[2:0] == $past(ptr[2:0]) + 3'h1)
        else $error("page pointer not wrapping");

endmodule

// File: core/dme_sync.sv
`timescale 1ns/1ps
`include "dme_consts.svh"

module dme_sync
#(
    parameter int WIDTH = 1
)
(
    // Destination clock
    input wire logic clk_i,
    input wire logic reset_i,
    // Levels
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta;

    // =================================================================
    // Two-stage level synchroniser
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            meta <= {WIDTH{`DME_SYNC_RESET}};
            sync_o <= {WIDTH{`DME_SYNC_RESET}};
        end
        else
        begin
            meta <= async_i;
            sync_o <= meta;
        end
    end

endmodule

// File: core/dme_txo.sv
`timescale 1ns/1ps
`include "dme_consts.svh"

module dme_txo
    import dme_pkg::*;
(
    // Link clock and power-up reset
    input wire logic transmit_only_clock_i,
    input wire logic reset_i,
    // From system domain
    input wire logic bidir_mode_i,
    input wire dme_byte_t fetch_data_i,
    // Serial stream
    output logic tx_bit_o,
    output logic tx_oe_o,
    output logic req_tgl_o
);

    logic mode_l;
    logic [3:0] init_cnt;
    logic [3:0] next_init;
    logic started;
    logic next_started;
    logic [3:0] slot;
    logic [3:0] next_slot;
    dme_byte_t shreg;
    dme_byte_t next_shreg;
    logic next_bit;
    logic next_oe;
    logic next_req;
    logic sh_msb;
    logic fd_msb;

    assign sh_msb = shreg[6];
    assign fd_msb = fetch_data_i[7];

    dme_sync #(.WIDTH(1)) u_mode_sync (
        .clk_i(transmit_only_clock_i),
        .reset_i(reset_i),
        .async_i(bidir_mode_i),
        .sync_o(mode_l)
    );

    // =================================================================
    // Bit slot sequencer
    // The fetched byte is not synchronised: it settles a few system
    // cycles after each request and is held for nine link periods.
    always_comb
    begin
        next_init = init_cnt;
        next_started = started;
        next_slot = slot;
        next_shreg = shreg;
        next_bit = tx_bit_o;
        next_oe = tx_oe_o;
        next_req = req_tgl_o;
        if (mode_l)
        begin
            next_oe = 1'b0;
            next_bit = 1'b1;
        end
        else if (!started && init_cnt != `DME_INIT_LAST)
        begin
            next_init = init_cnt + 4'h1;
        end
        else if (!started || slot == `DME_NULL_SLOT)
        begin
            next_started = 1'b1;
            next_slot = 4'h0;
            next_shreg = fetch_data_i;
            next_bit = fetch_data_i[7];
            next_oe = 1'b1;
            next_req = ~req_tgl_o;
        end
        else if (slot == `DME_LAST_BIT)
        begin
            next_slot = slot + 4'h1;
            next_oe = 1'b0;
            next_bit = 1'b1;
        end
        else
        begin
            next_slot = slot + 4'h1;
            next_bit = shreg[6];
            next_shreg = {shreg[6:0], 1'b0};
        end
    end

    // New bit appears on the rising link edge
    always_ff @(posedge transmit_only_clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            init_cnt <= 4'h0;
            started <= 1'b0;
            slot <= 4'h0;
            shreg <= 8'h00;
            tx_bit_o <= 1'b1;
            tx_oe_o <= 1'b0;
            req_tgl_o <= 1'b0;
        end
        else
        begin
            init_cnt <= next_init;
            started <= next_started;
            slot <= next_slot;
            shreg <= next_shreg;
            tx_bit_o <= next_bit;
            tx_oe_o <= next_oe;
            req_tgl_o <= next_req;
        end
    end

    // =================================================================
    // Checks
    sequence s_null_then_msb;
        !tx_oe_o ##1 tx_oe_o;
    endsequence

    chk_init_silent: assert property (
        @(posedge transmit_only_clock_i) disable iff (reset_i)
        !started |-> !tx_oe_o)
        else $error("data driven during synchronisation");

    chk_first_msb: assert property (
        @(posedge transmit_only_clock_i) disable iff (reset_i)
        $rose(started) |-> ($past(init_cnt) == `DME_INIT_LAST)
            && tx_oe_o && (tx_bit_o == $past(fd_msb)))
        else $error("first bit not msb on tenth edge");

    chk_byte_order: assert property (
        @(posedge transmit_only_clock_i) disable iff (reset_i)
        (started && !mode_l && slot < `DME_LAST_BIT)
            |=> (tx_bit_o == $past(sh_msb)))
        else $error("bit order not msb first");

    chk_null_slot: assert property (
        @(posedge transmit_only_clock_i) disable iff (reset_i)
        (started && !mode_l && slot == `DME_LAST_BIT) ##1 !mode_l
            |-> s_null_then_msb)
        else $error("ninth slot not null");

endmodule

// File: dv/dme_host.sv
`timescale 1ns/1ps
module dme_host
    import dme_pkg::*;
(
    // Bus side
    input wire logic clk_i,
    input wire logic sda_i,
    output logic tclk_o,
    output logic scl_o,
    output logic sda_low_o
);
    initial
    begin
        tclk_o = 1'b0;
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    // =====================================================
    // Link clock, still outside calls
    task automatic link(input int n);
        repeat (n)
        begin
            #62.5 tclk_o = 1'b1;
            #62.5 tclk_o = 1'b0;
        end
    endtask

    task automatic wen(input logic v);
        @(negedge clk_i) tclk_o = v;
    endtask

    // =====================================================
    // Scl first, sda later, so no false start or stop
    task automatic step(input logic c, input logic d);
        repeat (8) @(negedge clk_i);
        scl_o = c;
        repeat (8) @(negedge clk_i);
        sda_low_o = ~d;
    endtask

    task automatic start();
        step(1'b0, 1'b1);
        step(1'b1, 1'b0);
    endtask

    task automatic stop();
        step(1'b0, 1'b0);
        step(1'b1, 1'b1);
    endtask

    // Byte plus acknowledge slot, msb first
    task automatic xbyte(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--)
        begin
            step(1'b0, d[i]);
            step(1'b1, d[i]);
            r[i] = sda_i;
        end
    endtask
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import dme_pkg::*;
;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic tclk, scl, sda_low, sda_o, sda_oe, bidir, busy, sda;
    dme_byte_t m [128];
    logic [15:0] lf = 16'h0013;
    logic [8:0] r;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    int bcnt = 0;
    int s;

    // Pull-up on the shared line
    assign sda = (sda_oe ? sda_o : 1'b1) & ~sda_low;

    initial
    begin
        forever #4 clk_i = ~clk_i;
    end

    dme_port #(.WRITE_CYCLES(1000)) dme_port_i (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .transmit_only_clock_i(tclk),
        .scl_i(scl),
        .sda_i(sda),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe),
        .bidir_mode_o(bidir),
        .write_busy_o(busy)
    );

    dme_host dme_host_i (
        .clk_i(clk_i),
        .sda_i(sda),
        .tclk_o(tclk),
        .scl_o(scl),
        .sda_low_o(sda_low)
    );

    function automatic dme_byte_t rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf[7:0];
    endfunction

    task automatic cmp(input string w, input logic [15:0] e,
                       input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Hang guard and busy length counter
    // Falling edge, so busy is read where it has settled
    always @(negedge clk_i)
    begin
        cyc++;
        if (busy === 1'b1)
            bcnt++;
        if (cyc == 60000)
        begin
            fails++;
            give_verdict();
        end
    end

    task automatic ctrl(input logic rw, input logic e);
        dme_byte_t x;
        x = rnd();
        dme_host_i.start();
        dme_host_i.xbyte({4'ha, x[2:0], rw, 1'b1}, r);
        cmp("ack", e, r[0]);
    endtask

    task automatic wr(input int a, input int n, input logic en);
        dme_byte_t d;
        dme_host_i.wen(en);
        ctrl(1'b0, 1'b0);
        dme_host_i.xbyte({a[7:0], 1'b1}, r);
        for (int i = 0; i < n; i++)
        begin
            d = rnd();
            dme_host_i.xbyte({d, 1'b1}, r);
            cmp("ack", 0, r[0]);
            if (en)
                m[a / 8 * 8 + (a + i) % 8] = d;
        end
        cmp("busy", 0, busy);
        bcnt = 0;
        dme_host_i.stop();
        repeat (16) @(negedge clk_i);
        cmp("busy", en, busy);
        if (en)
        begin
            ctrl(1'b0, 1'b1);
            dme_host_i.stop();
            for (int i = 0; i < 1500 && busy !== 1'b0; i++)
                @(negedge clk_i);
            cmp("busy cycles", 1000, bcnt);
        end
    endtask

    // Random read, sequential across the 7-bit wrap
    task automatic rd(input int a, input int n);
        ctrl(1'b0, 1'b0);
        dme_host_i.xbyte({a[7:0], 1'b1}, r);
        ctrl(1'b1, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            dme_host_i.xbyte({8'hff, i == n - 1}, r);
            cmp("data", m[(a + i) % 128], r[8:1]);
        end
        dme_host_i.stop();
    endtask

    initial
    begin
        for (int k = 0; k < 128; k++)
        begin
            m[k] = rnd();
            dme_port_i.mem[k] = m[k];
        end
        fork
            dme_host_i.link(1);
            repeat (16) @(negedge clk_i);
        join
        reset_i = 1'b0;
        cmp("mode", 0, bidir);
        // =====================================================
        // Stream past the array end to see the wrap
        for (int n = 1; n < 1180; n++)
        begin
            dme_host_i.link(1);
            s = (n + 8) % 9;
            if (n < 10 || s == 8)
                cmp("oe", 0, sda_oe);
            else
                cmp("bit", {1'b1, m[(n - 10) / 9 % 128][7 - s]},
                    {sda_oe, sda_o});
        end
        // =====================================================
        // Mode switch, then stream clock ignored
        dme_host_i.step(1'b0, 1'b1);
        cmp("mode", 1, bidir);
        dme_host_i.link(9);
        cmp("mode", 1, bidir);
        cmp("oe", 0, sda_oe);
        dme_host_i.start();
        dme_host_i.xbyte(9'h0b3, r);
        cmp("ack", 1, r[0]);
        dme_host_i.stop();
        wr(126, 1, 1'b1);
        wr(19, 9, 1'b1);
        wr(64, 2, 1'b0);
        rd(16, 8);
        rd(126, 4);
        rd(62, 4);
        reset_i = 1'b1;
        repeat (16) @(negedge clk_i);
        reset_i = 1'b0;
        cmp("mode", 0, bidir);
        // =====================================================
        // Stream restarts after a new power-up
        dme_host_i.link(9);
        cmp("oe", 0, sda_oe);
        dme_host_i.link(1);
        cmp("bit", {1'b1, m[0][7]}, {sda_oe, sda_o});
        give_verdict();
    end
endmodule
